// File: hw/vlan_table_defines.vh
// constants for the vlan and learned address table engine
`ifndef VLAN_TABLE_DEFINES_VH
`define VLAN_TABLE_DEFINES_VH

// ==========================================
// register addresses
`define REG_CTRL5 8'h05
`define REG_TBL_SEL 8'h6e
`define REG_TBL_IDX 8'h6f
`define REG_DATA_FIRST 8'h70
`define REG_DATA_LAST 8'h78
`define CTRL5_RESET 8'h00
`define CTRL5_VLAN_EN_BIT 7
`define DATA_BYTES 4'h9

// ==========================================
// table select fields
`define SEL_READ_BIT 4
`define SEL_TBL_MSB 3
`define SEL_TBL_LSB 2
`define SEL_IDX_HI_MSB 1
`define TBL_VLAN 2'h1
`define TBL_DYN 2'h2

// ==========================================
// vlan entry layout
`define VLAN_W 22
`define VLAN_ENTRIES 16
`define VLAN_RESET 22'h3f_0001
`define VLAN_VALID_BIT 21
`define VLAN_MEMB_MSB 20
`define VLAN_MEMB_LSB 16
`define VLAN_FID_MSB 15
`define VLAN_FID_LSB 12
`define VLAN_VID_MSB 11
`define VLAN_VID_LSB 0
`define NULL_VID 12'h000
`define ALL_PORTS 5'h1f

// ==========================================
// learned entry layout
`define DYN_ENTRIES 11'h400
`define DYN_EMPTY_BIT 68
`define DYN_CNT_MSB 67
`define DYN_CNT_LSB 58
`define DYN_TS_MSB 57
`define DYN_TS_LSB 56
`define DYN_NOT_READY_BIT 55
`define DYN_PORT_MSB 54
`define DYN_PORT_LSB 52
`define DYN_FID_MSB 51
`define DYN_FID_LSB 48
`define TS_FRESH 2'h3

`endif

// File: hw/vlan_table.v
// sixteen-entry vlan table with host access and vid match lookup
`timescale 1ns/1ps
`include "vlan_table_defines.vh"

module vlan_table (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // host access
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [`VLAN_W-1:0] wr_entry,
  input wire [3:0] rd_idx,
  output wire [`VLAN_W-1:0] rd_entry,
  // ingress lookup
  input wire [11:0] look_vid,
  output reg look_hit,
  output reg [`VLAN_W-1:0] look_entry
);

  wire [`VLAN_W*`VLAN_ENTRIES-1:0] flat;
  integer i;

  // ==========================================
  // storage
  genvar g;
  generate
    for (g = 0; g < `VLAN_ENTRIES; g = g + 1) begin : gen_entry
      reg [`VLAN_W-1:0] entry_q;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          entry_q <= `VLAN_RESET; // see (R2)
        end else if (wr_en && wr_idx == g) begin
          entry_q <= wr_entry; // see (R8)
        end
      end
      assign flat[g*`VLAN_W +: `VLAN_W] = entry_q;
    end
  endgenerate

  assign rd_entry = flat[rd_idx*`VLAN_W +: `VLAN_W];

  // ==========================================
  // lookup: lowest matching entry wins; an invalid match means drop
  always @* begin
    look_hit = 1'b0;
    look_entry = {`VLAN_W{1'b0}};
    for (i = `VLAN_ENTRIES - 1; i >= 0; i = i - 1) begin
      if (flat[i*`VLAN_W + `VLAN_VID_LSB +: 12] == look_vid) begin
        look_hit = flat[i*`VLAN_W + `VLAN_VALID_BIT]; // see (R6)
        look_entry = flat[i*`VLAN_W +: `VLAN_W];
      end
    end
  end

endmodule

// File: hw/vlan_and_mac_table_access.v
// vlan and learned address table engine with indirect host access
// ==========================================
// Summary of operation
// (R1) vlan lookup only when control bit enabled
// (R2) sixteen vlan entries, documented reset values
// (R3) unknown destination floods to vlan members
// (R4) address lookups keyed by filter group
// (R5) vid from tag, else port default
// (R6) invalid vlan drops packet, no learning
// (R7) flood excludes ingress; unknown source learned
// (R8) index write triggers selected table operation
// (R9) vlan read returns entry in data bytes
// (R10) host loads data before vlan write
// (R11) host writes vlan entries from zero
// (R12) 1k learned entries, device maintained only
// (R13) empty flag and count minus one
// (R14) two-bit timestamp per learned entry
// (R15) not-ready bit until entry available
// (R16) source port encoded zero to four
// (R17) learned read fills nine data bytes
// (R18) count and empty in first bytes
// (R19) host sets high index bits first
// (R20) select low bits extend the index
// (R21) data bytes hold last read result
`timescale 1ns/1ps
`include "vlan_table_defines.vh"

module vlan_and_mac_table_access (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // management register access
  input wire reg_wr_en,
  input wire [7:0] reg_wr_addr,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_addr,
  output wire [7:0] reg_rd_data,
  // ingress lookup request
  input wire pkt_valid,
  output wire pkt_ready,
  input wire [2:0] pkt_port,
  input wire pkt_tagged,
  input wire [11:0] pkt_vid,
  input wire [47:0] pkt_da,
  input wire [47:0] pkt_sa,
  input wire [59:0] port_default_vid,
  input wire da_static_hit,
  input wire [4:0] da_static_ports,
  // forwarding decision
  output wire fwd_valid,
  output wire fwd_drop,
  output wire [4:0] fwd_ports,
  output wire [11:0] fwd_vid
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SCAN = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  // port number 0..4 to port mask bit
  function [4:0] port_mask;
    input [2:0] p;
    begin
      port_mask = 5'h01 << p;
    end
  endfunction

  // ==========================================
  // state
  reg [7:0] ctrl5_q, ctrl5_d, sel_q, sel_d, idx_q, idx_d, rd_data_q, rd_data_d;
  reg [71:0] data_q, data_d;
  reg dyn_pend_q, dyn_pend_d, ready_q, ready_d, drop_q, drop_d, st_hit_q, st_hit_d;
  reg da_hit_q, da_hit_d, sa_hit_q, sa_hit_d, fwd_valid_q, fwd_valid_d, fwd_drop_q, fwd_drop_d;
  reg [9:0] dyn_idx_q, dyn_idx_d, scan_q, scan_d, sa_idx_q, sa_idx_d;
  reg [1:0] state_q, state_d;
  reg [10:0] count_q, count_d;
  reg [2:0] in_port_q, in_port_d, da_port_q, da_port_d;
  reg [11:0] vid_q, vid_d, fwd_vid_q, fwd_vid_d;
  reg [3:0] fid_q, fid_d;
  reg [4:0] memb_q, memb_d, st_ports_q, st_ports_d, fwd_ports_q, fwd_ports_d;
  reg [47:0] da_q, da_d, sa_q, sa_d;

  // learned table storage; contents beyond the count are never used
  reg [47:0] mac_mem [0:1023];
  reg [3:0] fid_mem [0:1023];
  reg [2:0] port_mem [0:1023];
  reg [1:0] ts_mem [0:1023];
  reg mem_new, mem_refresh, vt_wr_en;
  reg [9:0] mem_idx;
  reg [11:0] look_vid;
  reg [3:0] byte_sel;
  reg [68:0] dyn_entry;
  wire [`VLAN_W-1:0] vt_rd_entry, vt_entry;
  wire vt_hit;
  wire vlan_en = ctrl5_q[`CTRL5_VLAN_EN_BIT];
  wire [10:0] count_m1 = count_q - 11'h001;
  wire [10:0] scan_next = {1'b0, scan_q} + 11'h001;
  wire trigger = reg_wr_en && reg_wr_addr == `REG_TBL_IDX;
  wire sel_read = sel_q[`SEL_READ_BIT];
  wire [1:0] sel_tbl = sel_q[`SEL_TBL_MSB:`SEL_TBL_LSB];
  wire accept = pkt_valid && ready_q;

  vlan_table u_vlan_table (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(vt_wr_en),
    .wr_idx(reg_wr_data[3:0]),
    .wr_entry(data_q[`VLAN_W-1:0]),
    .rd_idx(reg_wr_data[3:0]),
    .rd_entry(vt_rd_entry),
    .look_vid(look_vid),
    .look_hit(vt_hit),
    .look_entry(vt_entry)
  );

  // ==========================================
  // host side: registers, triggers and learned reads
  always @* begin
    ctrl5_d = (reg_wr_en && reg_wr_addr == `REG_CTRL5) ? reg_wr_data : ctrl5_q;
    sel_d = (reg_wr_en && reg_wr_addr == `REG_TBL_SEL) ? reg_wr_data : sel_q;
    idx_d = idx_q;
    data_d = data_q;
    dyn_pend_d = dyn_pend_q;
    dyn_idx_d = dyn_idx_q;
    vt_wr_en = 1'b0;
    byte_sel = 4'h0;
    // assembled learned entry for the requested index
    dyn_entry = {69{1'b0}};
    dyn_entry[`DYN_EMPTY_BIT] = count_q == 11'h000; // see (R13)
    if (count_q != 11'h000) begin
      dyn_entry[`DYN_CNT_MSB:`DYN_CNT_LSB] = count_m1[9:0]; // see (R13)
    end
    if ({1'b0, dyn_idx_q} < count_q) begin
      dyn_entry[`DYN_TS_MSB:`DYN_TS_LSB] = ts_mem[dyn_idx_q]; // see (R14)
      dyn_entry[`DYN_PORT_MSB:`DYN_PORT_LSB] = port_mem[dyn_idx_q]; // see (R16)
      dyn_entry[`DYN_FID_MSB:`DYN_FID_LSB] = fid_mem[dyn_idx_q];
      dyn_entry[47:0] = mac_mem[dyn_idx_q];
    end
    if (reg_wr_en) begin
      if (reg_wr_addr >= `REG_DATA_FIRST && reg_wr_addr <= `REG_DATA_LAST) begin
        byte_sel = reg_wr_addr[3:0];
        data_d[(`DATA_BYTES - 4'h1 - byte_sel)*8 +: 8] = reg_wr_data; // see (R10)
      end
    end
    // a finished learned read lands once the engine is idle
    if (dyn_pend_q && state_q == ST_IDLE) begin
      data_d = {3'h0, dyn_entry}; // see (R17)
      dyn_pend_d = 1'b0;
    end
    if (trigger) begin
      idx_d = reg_wr_data;
      if (sel_read && sel_tbl == `TBL_VLAN) begin
        data_d[23:0] = {2'b00, vt_rd_entry}; // see (R9)
      end else if (sel_tbl == `TBL_VLAN) begin
        vt_wr_en = 1'b1; // see (R8)
      end
      if (sel_read && sel_tbl == `TBL_DYN) begin
        dyn_pend_d = 1'b1;
        dyn_idx_d = {sel_q[`SEL_IDX_HI_MSB:0], reg_wr_data}; // see (R20)
        data_d[`DYN_NOT_READY_BIT] = 1'b1; // see (R15)
      end
    end
  end

  // ==========================================
  // register read port, one cycle behind the address
  always @* begin
    rd_data_d = 8'h00;
    if (reg_rd_addr == `REG_CTRL5) begin
      rd_data_d = ctrl5_q;
    end else if (reg_rd_addr == `REG_TBL_SEL) begin
      rd_data_d = sel_q;
    end else if (reg_rd_addr == `REG_TBL_IDX) begin
      rd_data_d = idx_q;
    end else if (reg_rd_addr >= `REG_DATA_FIRST && reg_rd_addr <= `REG_DATA_LAST) begin
      rd_data_d = data_q[(`DATA_BYTES - 4'h1 - reg_rd_addr[3:0])*8 +: 8]; // see (R18)
    end
  end

  // ==========================================
  // ingress lookup engine
  always @* begin
    state_d = state_q;
    count_d = count_q;
    scan_d = scan_q;
    in_port_d = in_port_q;
    vid_d = vid_q;
    fid_d = fid_q;
    memb_d = memb_q;
    drop_d = drop_q;
    da_d = da_q;
    sa_d = sa_q;
    st_hit_d = st_hit_q;
    st_ports_d = st_ports_q;
    da_hit_d = da_hit_q;
    da_port_d = da_port_q;
    sa_hit_d = sa_hit_q;
    sa_idx_d = sa_idx_q;
    fwd_valid_d = 1'b0;
    fwd_drop_d = fwd_drop_q;
    fwd_ports_d = fwd_ports_q;
    fwd_vid_d = fwd_vid_q;
    mem_new = 1'b0;
    mem_refresh = 1'b0;
    mem_idx = sa_idx_q;
    look_vid = pkt_vid;
    if (!pkt_tagged || pkt_vid == `NULL_VID) begin
      look_vid = port_default_vid[pkt_port*12 +: 12]; // see (R5)
    end
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          in_port_d = pkt_port;
          da_d = pkt_da;
          sa_d = pkt_sa;
          st_hit_d = da_static_hit;
          st_ports_d = da_static_ports;
          da_hit_d = 1'b0;
          sa_hit_d = 1'b0;
          scan_d = 10'h000;
          vid_d = vlan_en ? look_vid : pkt_vid;
          fid_d = 4'h0;
          memb_d = `ALL_PORTS;
          drop_d = 1'b0;
          if (vlan_en) begin // see (R1)
            fid_d = vt_entry[`VLAN_FID_MSB:`VLAN_FID_LSB]; // see (R4)
            memb_d = vt_entry[`VLAN_MEMB_MSB:`VLAN_MEMB_LSB];
            drop_d = !vt_hit; // see (R6)
          end
          state_d = ((vlan_en && !vt_hit) || count_q == 11'h000) ? ST_DONE : ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (fid_mem[scan_q] == fid_q && mac_mem[scan_q] == da_q) begin
          da_hit_d = 1'b1; // see (R4)
          da_port_d = port_mem[scan_q];
        end
        if (fid_mem[scan_q] == fid_q && mac_mem[scan_q] == sa_q) begin
          sa_hit_d = 1'b1;
          sa_idx_d = scan_q;
        end
        scan_d = scan_next[9:0];
        if (scan_next == count_q) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
        fwd_valid_d = 1'b1;
        fwd_drop_d = drop_q;
        fwd_vid_d = vid_q;
        if (drop_q) begin
          fwd_ports_d = 5'h00; // see (R6)
        end else if (st_hit_q) begin
          fwd_ports_d = st_ports_q & ~port_mask(in_port_q);
        end else if (da_hit_q) begin
          fwd_ports_d = port_mask(da_port_q) & ~port_mask(in_port_q);
        end else begin
          fwd_ports_d = memb_q & ~port_mask(in_port_q); // see (R3) (R7)
        end
        // a known source is refreshed and may migrate to a new port
        if (!drop_q && sa_hit_q) begin
          mem_refresh = 1'b1;
        end else if (!drop_q && count_q != `DYN_ENTRIES) begin
          mem_new = 1'b1; // see (R7) (R12)
          mem_idx = count_q[9:0];
          count_d = count_q + 11'h001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // pending host reads take the idle slot before the next packet
    ready_d = state_d == ST_IDLE && !dyn_pend_d;
  end

  // learned storage is written only by the engine, never by the host
  always @(posedge ref_clk) begin
    if (mem_new) begin
      mac_mem[mem_idx] <= sa_q; // see (R12)
      fid_mem[mem_idx] <= fid_q;
    end
    if (mem_new || mem_refresh) begin
      port_mem[mem_idx] <= in_port_q; // see (R16)
      ts_mem[mem_idx] <= `TS_FRESH; // see (R14)
    end
  end

  // ==========================================
  // flops
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl5_q <= `CTRL5_RESET;
      sel_q <= 8'h00;
      idx_q <= 8'h00;
      data_q <= {72{1'b0}};
      rd_data_q <= 8'h00;
      dyn_pend_q <= 1'b0;
      dyn_idx_q <= 10'h000;
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
      count_q <= 11'h000;
      scan_q <= 10'h000;
      in_port_q <= 3'h0;
      vid_q <= 12'h000;
      fid_q <= 4'h0;
      memb_q <= 5'h00;
      drop_q <= 1'b0;
      da_q <= 48'h0000_0000_0000;
      sa_q <= 48'h0000_0000_0000;
      st_hit_q <= 1'b0;
      st_ports_q <= 5'h00;
      da_hit_q <= 1'b0;
      da_port_q <= 3'h0;
      sa_hit_q <= 1'b0;
      sa_idx_q <= 10'h000;
      fwd_valid_q <= 1'b0;
      fwd_drop_q <= 1'b0;
      fwd_ports_q <= 5'h00;
      fwd_vid_q <= 12'h000;
    end else begin
      ctrl5_q <= ctrl5_d;
      sel_q <= sel_d;
      idx_q <= idx_d;
      data_q <= data_d; // see (R21)
      rd_data_q <= rd_data_d;
      dyn_pend_q <= dyn_pend_d;
      dyn_idx_q <= dyn_idx_d;
      state_q <= state_d;
      ready_q <= ready_d;
      count_q <= count_d;
      scan_q <= scan_d;
      in_port_q <= in_port_d;
      vid_q <= vid_d;
      fid_q <= fid_d;
      memb_q <= memb_d;
      drop_q <= drop_d;
      da_q <= da_d;
      sa_q <= sa_d;
      st_hit_q <= st_hit_d;
      st_ports_q <= st_ports_d;
      da_hit_q <= da_hit_d;
      da_port_q <= da_port_d;
      sa_hit_q <= sa_hit_d;
      sa_idx_q <= sa_idx_d;
      fwd_valid_q <= fwd_valid_d;
      fwd_drop_q <= fwd_drop_d;
      fwd_ports_q <= fwd_ports_d;
      fwd_vid_q <= fwd_vid_d;
    end
  end

  assign reg_rd_data = rd_data_q;
  assign pkt_ready = ready_q;
  assign fwd_valid = fwd_valid_q;
  assign fwd_drop = fwd_drop_q;
  assign fwd_ports = fwd_ports_q;
  assign fwd_vid = fwd_vid_q;

endmodule

// File: testbench/vlan_and_mac_table_access_sva.sv
// assertion checker on the table engine ports
`timescale 1ns/1ps
module vlan_and_mac_table_access_sva (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register access
  input wire reg_wr_en,
  input wire [7:0] reg_wr_addr,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_addr,
  input wire [7:0] reg_rd_data,
  // lookup request and decision
  input wire pkt_valid,
  input wire pkt_ready,
  input wire [2:0] pkt_port,
  input wire pkt_tagged,
  input wire [11:0] pkt_vid,
  input wire [59:0] port_default_vid,
  input wire da_static_hit,
  input wire [4:0] da_static_ports,
  input wire fwd_valid,
  input wire fwd_drop,
  input wire [4:0] fwd_ports,
  input wire [11:0] fwd_vid
);
  // ==========================================
  // request context captured at the taking edge
  reg on_q;
  reg en_q;
  reg hit_q;
  reg [2:0] port_q;
  reg [4:0] st_q;
  reg [11:0] vid_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_q <= 1'b0;
      en_q <= 1'b0;
      hit_q <= 1'b0;
      port_q <= 3'h0;
      st_q <= 5'h00;
      vid_q <= 12'h000;
    end else begin
      if (reg_wr_en && reg_wr_addr == 8'h05)
        on_q <= reg_wr_data[7];
      if (pkt_valid && pkt_ready) begin
        en_q <= on_q;
        hit_q <= da_static_hit;
        port_q <= pkt_port;
        st_q <= da_static_ports;
        vid_q <= (!pkt_tagged || pkt_vid == 12'h000) ? port_default_vid[12*pkt_port +: 12] : pkt_vid;
      end
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    pkt_valid && pkt_ready;
  endsequence
  property p_answer;
    s_take |-> ##[2:1000] fwd_valid;
  endproperty
  property p_busy;
    s_take |=> (!pkt_ready until fwd_valid);
  endproperty
  property p_drop_ports;
    fwd_valid && fwd_drop |-> fwd_ports == 5'h00;
  endproperty
  property p_mode_off;
    fwd_valid && !en_q |-> !fwd_drop;
  endproperty
  property p_excl_ingress;
    fwd_valid |-> !fwd_ports[port_q];
  endproperty
  property p_static;
    fwd_valid && hit_q && !fwd_drop |-> fwd_ports == (st_q & ~(5'h01 << port_q));
  endproperty
  property p_vid;
    fwd_valid && en_q && !fwd_drop |-> fwd_vid == vid_q;
  endproperty
  property p_mode_read;
    reg_rd_addr == 8'h05 |=> reg_rd_data[7] == $past(on_q);
  endproperty
  a_answer: assert property (p_answer) else $error("no decision after request");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_drop_ports: assert property (p_drop_ports) else $error("dropped packet forwarded");
  a_mode_off: assert property (p_mode_off) else $error("drop with vlan mode off");
  a_excl_ingress: assert property (p_excl_ingress) else $error("ingress port forwarded");
  a_static: assert property (p_static) else $error("static result ignored");
  a_vid: assert property (p_vid) else $error("wrong vid assigned");
  a_mode_read: assert property (p_mode_read) else $error("mode bit readback wrong");
endmodule

// File: testbench/mgmt_host_model.sv
// management host model: register writes, reads and table operations
`timescale 1ns/1ps
module mgmt_host_model (
  // clock
  input wire ref_clk,
  // register access
  output reg reg_wr_en,
  output reg [7:0] reg_wr_addr,
  output reg [7:0] reg_wr_data,
  output reg [7:0] reg_rd_addr,
  input wire [7:0] reg_rd_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_rd_addr = 8'h00;
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      #1;
      reg_wr_en = 1'b1;
      reg_wr_addr = a;
      reg_wr_data = d;
      @(posedge ref_clk);
      #1;
      reg_wr_en = 1'b0;
      // released lines must not keep showing the last write
      reg_wr_addr = ~a;
      reg_wr_data = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      reg_rd_addr = a;
      @(posedge ref_clk);
      #1;
      d = reg_rd_data;
    end
  endtask
  task vlan_wr(input [3:0] idx, input [21:0] e);
    begin
      wr(8'h76, {2'b00, e[21:16]});
      wr(8'h77, e[15:8]);
      wr(8'h78, e[7:0]);
      wr(8'h6e, 8'h04);
      wr(8'h6f, {4'h0, idx});
    end
  endtask
  task vlan_rd(input [3:0] idx, output [21:0] e);
    reg [7:0] b;
    begin
      wr(8'h6e, 8'h14);
      wr(8'h6f, {4'h0, idx});
      rd(8'h76, b);
      e[21:16] = b[5:0];
      rd(8'h77, b);
      e[15:8] = b;
      rd(8'h78, b);
      e[7:0] = b;
    end
  endtask
  task dyn_rd(input [7:0] sel, input [7:0] idx, output [68:0] e);
    reg [7:0] b;
    reg [7:0] a;
    int i;
    begin
      wr(8'h6e, sel);
      wr(8'h6f, idx);
      b = 8'h80;
      for (i = 0; i < 2000 && b[7] !== 1'b0; i++)
        rd(8'h72, b);
      e = 69'h0;
      for (a = 8'h70; a <= 8'h78; a = a + 8'h01) begin
        rd(a, b);
        e = {e[60:0], b};
      end
    end
  endtask
endmodule

// File: testbench/vlan_and_mac_table_access_tb.sv
// self-checking bench for the vlan and learned table engine
`timescale 1ns/1ps
module vlan_and_mac_table_access_tb;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg pkt_valid = 1'b0;
  reg [2:0] pkt_port = 3'h0;
  reg pkt_tagged = 1'b0;
  reg [11:0] pkt_vid = 12'h000;
  reg [47:0] pkt_da = 48'h0;
  reg [47:0] pkt_sa = 48'h0;
  reg [59:0] port_default_vid = {12'h013, 12'h012, 12'h011, 12'h010, 12'h015};
  reg da_static_hit = 1'b0;
  reg [4:0] da_static_ports = 5'h00;
  wire reg_wr_en, pkt_ready, fwd_valid, fwd_drop;
  wire [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
  wire [4:0] fwd_ports;
  wire [11:0] fwd_vid;
  int err_total = 0;
  int n_compared = 0;
  int i, n;
  reg [31:0] rs = 32'h0000_002a;
  reg [31:0] r;
  reg [31:0] lsa;
  reg [7:0] rb;
  reg [21:0] vt [0:15];
  reg [21:0] v;
  reg [68:0] e;
  reg [2:0] p, lp;
  reg [3:0] ei, lei;
  reg [11:0] ev;
  reg [4:0] ex;
  reg drop, have;
  vlan_and_mac_table_access dut_u (.ref_clk, .rst, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_rd_addr,
    .reg_rd_data, .pkt_valid, .pkt_ready, .pkt_port, .pkt_tagged, .pkt_vid, .pkt_da, .pkt_sa,
    .port_default_vid, .da_static_hit, .da_static_ports, .fwd_valid, .fwd_drop, .fwd_ports, .fwd_vid);
  mgmt_host_model host_u (.ref_clk, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_rd_addr, .reg_rd_data);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task chk(input logic [68:0] seen, input logic [68:0] exp);
    begin
      n_compared++;
      if (seen !== exp) begin
        err_total++;
        $display("wrong value at %0t seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // one lookup; fresh source address from a range used as destination only by the learned-destination check
  task send(input [2:0] pp, input t, input [11:0] vid, input [47:0] da, input h, input [4:0] sp);
    int k;
    begin
      pkt_port = pp;
      pkt_tagged = t;
      pkt_vid = vid;
      pkt_da = da;
      pkt_sa = {16'h0002, rnd()};
      da_static_hit = h;
      da_static_ports = sp;
      pkt_valid = 1'b1;
      for (k = 0; k < 100 && pkt_ready !== 1'b1; k++)
        @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
      pkt_valid = 1'b0;
      for (k = 0; k < 2000 && fwd_valid !== 1'b1; k++)
        @(posedge ref_clk) #1;
      chk(fwd_valid, 1'b1);
    end
  endtask
  initial begin
    #400_000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk) #1;
    for (i = 0; i < 16; i++) begin
      host_u.vlan_rd(i[3:0], v);
      chk(v, 22'h3f_0001);
    end
    host_u.dyn_rd(8'h18, 8'h00, e);
    chk(e, {1'b1, 68'h0});
    // vlan mode off: all ports are members, tag vid passes through
    send(3'h2, 1'b1, 12'h005, 48'h0, 1'b0, 5'h00);
    chk({fwd_drop, fwd_ports, fwd_vid}, {1'b0, 5'h1b, 12'h005});
    host_u.dyn_rd(8'h18, 8'h00, e);
    chk(e, {1'b0, 10'h000, 2'h3, 1'b0, 3'h2, 4'h0, pkt_sa});
    for (i = 0; i < 16; i++) begin
      r = rnd();
      vt[i] = {i[2:0] != 3'h5, r[4:0], r[11:8], 8'h01, i[3:0]};
      host_u.vlan_wr(i[3:0], vt[i]);
      host_u.vlan_rd(i[3:0], v);
      chk(v, vt[i]);
    end
    host_u.wr(8'h05, 8'h80);
    host_u.rd(8'h05, rb);
    chk(rb, 8'h80);
    n = 1;
    have = 1'b0;
    for (i = 0; i < 24; i++) begin
      r = rnd();
      p = (r[2:0] > 3'h4) ? (r[2:0] - 3'h4) : r[2:0];
      v = vt[r[7:4]];
      ev = (r[8] && !r[9]) ? v[11:0] : port_default_vid[12*p +: 12];
      ei = ev[3:0];
      drop = !vt[ei][21];
      ex = drop ? 5'h00 : ((r[10] ? r[15:11] : vt[ei][20:16]) & ~(5'h01 << p));
      send(p, r[8], r[9] ? 12'h000 : v[11:0], {16'h0003, rnd()}, r[10], r[15:11]);
      chk({fwd_drop, fwd_ports, drop ? 12'h000 : fwd_vid}, {drop, ex, drop ? 12'h000 : ev});
      if (!drop) begin
        n++;
        if (!have) begin
          have = 1'b1;
          lp = p;
          lei = ei;
          lsa = pkt_sa[31:0];
        end
      end
    end
    if (have) begin
      // learned destination under the same filter group goes to its port only
      p = (lp == 3'h4) ? 3'h0 : lp + 3'h1;
      send(p, 1'b1, vt[lei][11:0], {16'h0002, lsa}, 1'b0, 5'h00);
      chk({fwd_drop, fwd_ports}, {1'b0, 5'h01 << lp});
      n++;
    end
    host_u.dyn_rd(8'h18, 8'h00, e);
    chk(e[68:55], {1'b0, n[9:0] - 10'h001, 2'h3, 1'b0});
    host_u.dyn_rd(8'h19, 8'h00, e);
    chk(e[55:0], 56'h0);
    give_verdict;
  end
endmodule
bind vlan_and_mac_table_access vlan_and_mac_table_access_sva chk_u (.ref_clk, .rst, .reg_wr_en, .reg_wr_addr,
  .reg_wr_data, .reg_rd_addr, .reg_rd_data, .pkt_valid, .pkt_ready, .pkt_port, .pkt_tagged, .pkt_vid,
  .port_default_vid, .da_static_hit, .da_static_ports, .fwd_valid, .fwd_drop, .fwd_ports, .fwd_vid);
